// file: design/dual_rail_voltage_transition_ctrl.sv
// top: voltage code ramps, protection masking, startup drive and droop
// assumes raw protection comparators and pwm from analog/modulator logic
// Operation
// - a high single-section pulse pin at configuration disables it.
// - voltage commands for a disabled single section are rejected.
// - protection flags are masked in a ramp and for a delay after it.
// - the fast command ramps at 20 mV/us and the slow command at 5 mV/us.
// - total overcurrent latches the outputs off even during a ramp.
// - a valid command steps each addressed reference to its target code.
// - a command in a ramp retargets it without finishing the old target.
// - after power-up or off code, outputs float until the first pulse once the reference has left the off code.
// - after the first pulse, pulses switch 0/1 and driver enable is 1.
// - overvoltage may still turn on the low-side switch during startup.
// - memory mode with droop scales the droop gain by one quarter.
// - droop output is the sum of phase currents times a software gain.
`timescale 1ns/1ps
module dual_rail_voltage_transition_ctrl #(
    parameter int UNMASK_CYC = vrc_pkg::UNMASK_DELAY_CYC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins and analog-side inputs
    input wire logic singleStrapPin,
    input wire logic [1:0] pwmRequest,
    input wire vrc_pkg::prot_flags_t mainRawFlags,
    input wire vrc_pkg::prot_flags_t singleRawFlags,
    input wire logic totalCurrentLimitSense,
    input wire logic [vrc_pkg::PHASES*vrc_pkg::SENSE_W-1:0] phaseCurrent,
    // outputs to drivers and protection
    output vrc_pkg::drive_t mainDrive,
    output logic singleSectionPulseOut,
    output logic singleSectionPulseEn,
    output logic singleDriverEnable,
    output vrc_pkg::prot_flags_t mainFlags,
    output vrc_pkg::prot_flags_t singleFlags,
    output logic latchedOff,
    output logic [vrc_pkg::CODE_W-1:0] mainReference,
    output logic [vrc_pkg::CODE_W-1:0] singleReference,
    output logic [vrc_pkg::DROOP_W-1:0] droopOut
);
    localparam int CW = vrc_pkg::CODE_W;

    // strap and limit pin synchronisers: three flops, change on 2 == 3
    logic [2:0] strapSync_q;
    logic [2:0] limSync_q;
    logic strapClean_q;
    logic limClean_q;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strapSync_q <= 3'h0;
            limSync_q <= 3'h0;
            strapClean_q <= 1'b0;
            limClean_q <= 1'b0;
        end
        else
        begin
            strapSync_q <= {strapSync_q[1:0], singleStrapPin};
            limSync_q <= {limSync_q[1:0], totalCurrentLimitSense};
            if (strapSync_q[1] == strapSync_q[2])
                strapClean_q <= strapSync_q[2];
            if (limSync_q[1] == limSync_q[2])
                limClean_q <= limSync_q[2];
        end
    end

    // strap captured once, at the fifth edge after release: the filtered
    // level is first valid after the fourth
    logic [2:0] cfgCnt_q;
    logic singleDisabled_q;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfgCnt_q <= 3'h0;
            singleDisabled_q <= 1'b0;
        end
        else if (cfgCnt_q != 3'h5)
        begin
            cfgCnt_q <= cfgCnt_q + 3'h1;
            if (cfgCnt_q == 3'h4)
                singleDisabled_q <= strapClean_q;
        end
    end

    // wishbone decode
    logic wbReq;
    logic wbWrite;
    logic cmdWrite;
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWrite = wbReq && wb_we_i;
    assign cmdWrite = wbWrite && wb_adr_i == vrc_pkg::REG_CMD && wb_sel_i[1];

    logic [CW-1:0] cmdCode;
    logic cmdMain;
    logic cmdSingle;
    assign cmdCode = wb_dat_i[vrc_pkg::CMD_CODE_LSB +: CW];
    assign cmdMain = cmdWrite && wb_dat_i[vrc_pkg::CMD_MAIN_BIT];
    assign cmdSingle = cmdWrite && wb_dat_i[vrc_pkg::CMD_SINGLE_BIT]
        && !singleDisabled_q;

    // config bits: memory mode, droop enable, droop gain
    logic memMode_q;
    logic droopEn_q;
    logic [vrc_pkg::GAIN_W-1:0] droopGain_q;
    logic rejected_q;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            memMode_q <= 1'b0;
            droopEn_q <= 1'b0;
            droopGain_q <= vrc_pkg::GAIN_RST;
            rejected_q <= 1'b0;
        end
        else
        begin
            if (cmdWrite && wb_sel_i[2])
            begin
                memMode_q <= wb_dat_i[vrc_pkg::CMD_MEM_BIT];
                droopEn_q <= wb_dat_i[vrc_pkg::CMD_DROOP_BIT];
            end
            if (wbWrite && wb_adr_i == vrc_pkg::REG_GAIN && wb_sel_i[0])
                droopGain_q <= wb_dat_i[vrc_pkg::GAIN_W-1:0];
            // sticky reject flag, set wins over a status write clear
            if (cmdWrite && wb_dat_i[vrc_pkg::CMD_SINGLE_BIT]
                && singleDisabled_q)
                rejected_q <= 1'b1;
            else if (wbWrite && wb_adr_i == vrc_pkg::REG_STATUS)
                rejected_q <= 1'b0;
        end
    end

    // per-section ramp engines (0 = multi-phase, 1 = single-phase)
    logic [1:0] secCmd;
    logic [1:0] secRamping;
    logic [1:0] secMasked;
    logic [1:0] secStarting;
    logic [CW-1:0] secRef [2];
    assign secCmd = {cmdSingle, cmdMain};

    generate
        for (genvar s = 0; s < 2; s++)
        begin : g_sec
            vrc_pkg::ramp_state_t state_q;
            logic [CW-1:0] target_q;
            logic [CW-1:0] ref_q;
            logic fast_q;
            logic [vrc_pkg::STEP_CNT_W-1:0] stepCnt_q;
            logic [vrc_pkg::UNMASK_CNT_W-1:0] holdCnt_q;
            logic starting_q;
            logic [vrc_pkg::STEP_CNT_W-1:0] stepLen;
            assign stepLen = fast_q
                ? vrc_pkg::STEP_CNT_W'(vrc_pkg::FAST_STEP_CYC)
                : vrc_pkg::STEP_CNT_W'(vrc_pkg::SLOW_STEP_CYC);

            // target, slope and ramp state
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    state_q <= vrc_pkg::ST_IDLE;
                    target_q <= vrc_pkg::CODE_OFF;
                    ref_q <= vrc_pkg::CODE_OFF;
                    fast_q <= 1'b0;
                    stepCnt_q <= '0;
                    holdCnt_q <= '0;
                end
                else if (secCmd[s])
                begin
                    // new command retargets, even mid-ramp
                    target_q <= cmdCode;
                    fast_q <= wb_dat_i[vrc_pkg::CMD_FAST_BIT];
                    stepCnt_q <= '0;
                    state_q <= vrc_pkg::ST_RAMP;
                end
                else
                begin
                    unique case (state_q)
                        vrc_pkg::ST_IDLE:
                            state_q <= vrc_pkg::ST_IDLE;
                        vrc_pkg::ST_RAMP:
                        begin
                            if (ref_q == target_q)
                            begin
                                state_q <= vrc_pkg::ST_HOLD;
                                holdCnt_q <= '0;
                            end
                            else if (stepCnt_q == stepLen - 1'b1)
                            begin
                                stepCnt_q <= '0;
                                // one code step toward target
                                if (ref_q < target_q)
                                    ref_q <= ref_q + 1'b1;
                                else
                                    ref_q <= ref_q - 1'b1;
                            end
                            else
                                stepCnt_q <= stepCnt_q + 1'b1;
                        end
                        vrc_pkg::ST_HOLD:
                        begin
                            if (holdCnt_q ==
                                vrc_pkg::UNMASK_CNT_W'(UNMASK_CYC - 1))
                                state_q <= vrc_pkg::ST_IDLE;
                            else
                                holdCnt_q <= holdCnt_q + 1'b1;
                        end
                        default:
                            state_q <= vrc_pkg::ST_IDLE;
                    endcase
                end
            end

            // startup: sitting at the off code arms the no-low-side start
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    starting_q <= 1'b1;
                else if (ref_q == vrc_pkg::CODE_OFF)
                    starting_q <= 1'b1;
                else if (pwmRequest[s])
                    starting_q <= 1'b0;
            end

            assign secRamping[s] = state_q == vrc_pkg::ST_RAMP;
            assign secMasked[s] = state_q != vrc_pkg::ST_IDLE;
            assign secStarting[s] = starting_q;
            assign secRef[s] = ref_q;
        end
    endgenerate

    // total overcurrent latch; never masked by a ramp
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            latchedOff <= 1'b0;
        else if (limClean_q)
            latchedOff <= 1'b1;
    end

    // masked protection flags, registered
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mainFlags <= '0;
            singleFlags <= '0;
        end
        else
        begin
            mainFlags <= secMasked[0] ? '0 : mainRawFlags;
            singleFlags <= (secMasked[1] || singleDisabled_q)
                ? '0 : singleRawFlags;
        end
    end

    // driver outputs: off when latched, float while starting
    logic mainOverVoltPull;
    logic singleOverVoltPull;
    assign mainOverVoltPull = mainRawFlags.overVoltage;
    assign singleOverVoltPull = singleRawFlags.overVoltage
        && !singleDisabled_q;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mainDrive <= '0;
            singleSectionPulseOut <= 1'b0;
            singleSectionPulseEn <= 1'b0;
            singleDriverEnable <= 1'b0;
        end
        else
        begin
            mainDrive.pulse <= '0;
            if (latchedOff)
            begin
                mainDrive.pulseEn <= '0;
                mainDrive.driverEnable <= 1'b0;
            end
            else if (mainOverVoltPull)
            begin
                mainDrive.pulseEn <= '1;
                mainDrive.driverEnable <= 1'b1;
            end
            else
            begin
                mainDrive.pulse <= {vrc_pkg::PHASES{pwmRequest[0]}};
                mainDrive.pulseEn <= {vrc_pkg::PHASES{!secStarting[0]}};
                mainDrive.driverEnable <= !secStarting[0];
            end
            singleSectionPulseOut <= 1'b0;
            if (latchedOff || singleDisabled_q)
            begin
                singleSectionPulseEn <= 1'b0;
                singleDriverEnable <= 1'b0;
            end
            else if (singleOverVoltPull)
            begin
                singleSectionPulseEn <= 1'b1;
                singleDriverEnable <= 1'b1;
            end
            else
            begin
                singleSectionPulseOut <= pwmRequest[1];
                singleSectionPulseEn <= !secStarting[1];
                singleDriverEnable <= !secStarting[1];
            end
        end
    end

    // droop: sum of phase currents times gain, quarter in memory mode
    localparam int DROOP_W_SUM = vrc_pkg::SENSE_W + 3;
    logic [DROOP_W_SUM-1:0] phaseSum;
    always_comb
    begin
        phaseSum = '0;
        for (int p = 0; p < vrc_pkg::PHASES; p++)
            phaseSum = phaseSum + DROOP_W_SUM'(
                phaseCurrent[p*vrc_pkg::SENSE_W +: vrc_pkg::SENSE_W]);
    end
    logic [DROOP_W_SUM+vrc_pkg::GAIN_W-1:0] droopProd;
    assign droopProd = phaseSum * droopGain_q;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            droopOut <= '0;
        else if (!droopEn_q)
            droopOut <= '0;
        else if (memMode_q)
            droopOut <= vrc_pkg::DROOP_W'(droopProd >> 6);
        else
            droopOut <= droopProd[vrc_pkg::DROOP_W+3:4];
    end

    assign mainReference = secRef[0];
    assign singleReference = secRef[1];

    // register read-back and single-cycle ack
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wbReq;
            wb_dat_o <= '0;
            if (wbReq && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    vrc_pkg::REG_GAIN:
                        wb_dat_o <= {24'h0, droopGain_q};
                    vrc_pkg::REG_STATUS:
                        wb_dat_o <= {24'h0, latchedOff, rejected_q,
                            singleDisabled_q, secStarting, secRamping,
                            secMasked[0] | secMasked[1]};
                    vrc_pkg::REG_CODE:
                        wb_dat_o <= {16'h0, secRef[1], secRef[0]};
                    default:
                        wb_dat_o <= {14'h0, droopEn_q, memMode_q, 16'h0};
                endcase
            end
        end
    end

    // assertions
    AST_LATCH_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        latchedOff |=> !mainDrive.driverEnable)
        else $error("drivers enabled while latched off");
    AST_START_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        secStarting[0] && !mainOverVoltPull
        |=> !mainDrive.driverEnable)
        else $error("driver enabled during startup");
    AST_MASK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        secRamping[0] |=> mainFlags == '0)
        else $error("flags not masked during ramp");
    AST_REJECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        singleDisabled_q && cmdWrite |=> $stable(singleReference))
        else $error("disabled section accepted command");
    AST_RETARGET: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmdMain |=> g_sec[0].target_q == $past(cmdCode))
        else $error("target not replaced");
    AST_SINGLE_OFF: assert property (@(posedge ref_clk)
        disable iff (!rst_b) singleDisabled_q |=> !singleDriverEnable)
        else $error("disabled single section enables its driver");
endmodule

// file: design/vrc_pkg.sv
// package: constants and carrier types for the dual rail voltage
// transition control; no assumptions beyond a 250 MHz system clock
package vrc_pkg;
    localparam int CODE_W = 8;
    localparam int PHASES = 6;
    localparam int SENSE_W = 10;
    localparam int DROOP_W = 16;
    localparam int GAIN_W = 8;
    // clock rate and time figures
    localparam int CLK_MHZ = 250;
    localparam int STEP_MV_X100 = 500; // one code step, 5 mV, in mV/100
    localparam int FAST_SLOPE_MV_US = 20;
    localparam int SLOW_SLOPE_MV_US = 5;
    // cycles per code step: step / slope, rounded down (shortest time)
    localparam int FAST_STEP_CYC =
        (STEP_MV_X100 * CLK_MHZ) / (FAST_SLOPE_MV_US * 100);
    localparam int SLOW_STEP_CYC =
        (STEP_MV_X100 * CLK_MHZ) / (SLOW_SLOPE_MV_US * 100);
    localparam int STEP_CNT_W = 10;
    localparam int UNMASK_DELAY_NS = 2000;
    localparam int UNMASK_DELAY_CYC = (UNMASK_DELAY_NS * CLK_MHZ) / 1000;
    localparam int UNMASK_CNT_W = 10;
    // reset values
    localparam logic [CODE_W-1:0] CODE_OFF = 8'h00;
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h10;
    // Wishbone register byte offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_GAIN = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_CODE = 4'hc;
    // command register field positions
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_MAIN_BIT = 8;
    localparam int CMD_SINGLE_BIT = 9;
    localparam int CMD_FAST_BIT = 10;
    localparam int CMD_MEM_BIT = 16;
    localparam int CMD_DROOP_BIT = 17;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RAMP = 2'b01,
        ST_HOLD = 2'b11
    } ramp_state_t;

    typedef struct packed {
        logic overVoltage;
        logic underVoltage;
        logic overCurrent;
    } prot_flags_t;

    typedef struct packed {
        logic [PHASES-1:0] pulse;
        logic [PHASES-1:0] pulseEn;
        logic driverEnable;
    } drive_t;
endpackage

// file: dv/power_stage_model.sv
// model: gate drivers and power stage behind the six main phases
// assumes the bench sets the load current that each phase carries
`timescale 1ns/1ps
module power_stage_model
(
    // drive from the controller
    input wire vrc_pkg::drive_t drive,
    input wire logic [vrc_pkg::SENSE_W-1:0] loadLevel,
    // sensed currents and switch state
    output logic [vrc_pkg::PHASES*vrc_pkg::SENSE_W-1:0] phaseCurrent,
    output logic [vrc_pkg::PHASES-1:0] lowSideOn
);
    // every phase carries the same share of the load
    always_comb
    begin
        for (int i = 0; i < vrc_pkg::PHASES; i++)
        begin
            phaseCurrent[i*vrc_pkg::SENSE_W +: vrc_pkg::SENSE_W] = loadLevel;
        end
    end
    // low side conducts only while the pin is driven low
    assign lowSideOn = drive.pulseEn & ~drive.pulse;
endmodule

// file: dv/test_dual_rail_voltage_transition_ctrl.sv
// bench: self-checking scenarios for the voltage transition control
// assumes the design package and the power stage model are compiled first
`timescale 1ns/1ps
module test_dual_rail_voltage_transition_ctrl;
    localparam int UNMASK = 4;
    logic ref_clk, rst_b, wbCyc, wbStb, wbWe, wbAck, strap, limitSense;
    logic latchedOff;
    logic [3:0] wbAdr;
    logic [31:0] wbDat, wbDatOut, rd;
    logic [1:0] pwmReq;
    logic [9:0] loadLevel;
    logic [59:0] phaseCurrent;
    logic [5:0] lowSideOn;
    logic [7:0] mainRef, singleRef;
    logic [15:0] droopOut;
    vrc_pkg::prot_flags_t mainRaw, mainFlags;
    vrc_pkg::drive_t mainDrive;
    int errors = 0;
    int checkCount = 0;
    int n;

    dual_rail_voltage_transition_ctrl #(.UNMASK_CYC(UNMASK)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatOut),
        .wb_ack_o(wbAck), .singleStrapPin(strap), .pwmRequest(pwmReq),
        .mainRawFlags(mainRaw), .singleRawFlags(3'h0),
        .totalCurrentLimitSense(limitSense), .phaseCurrent(phaseCurrent),
        .mainDrive(mainDrive), .singleSectionPulseOut(),
        .singleSectionPulseEn(), .singleDriverEnable(),
        .mainFlags(mainFlags), .singleFlags(), .latchedOff(latchedOff),
        .mainReference(mainRef), .singleReference(singleRef),
        .droopOut(droopOut));

    power_stage_model u_stage (.drive(mainDrive), .loadLevel(loadLevel),
        .phaseCurrent(phaseCurrent), .lowSideOn(lowSideOn));

    // free running clock, 4 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // classic single cycle; held until ack is sampled high
    task automatic wbXfer(input logic we, input logic [3:0] adr,
                          input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= d;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (wbAck !== 1'b1 && k < 20);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (wbAck !== 1'b1)
        begin
            check("bus ack", 0, 1);
            give_verdict();
        end
    endtask

    // bounded wait for the main reference to reach a code
    task automatic waitMain(input logic [7:0] code, input int bound);
        n = 0;
        while (mainRef !== code && n < bound)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (mainRef !== code)
        begin
            check("ramp end", 0, 1);
            give_verdict();
        end
    endtask

    task automatic doReset();
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic testResetValues();
        wbXfer(0, vrc_pkg::REG_GAIN, 0);
        check("gain", rd, {24'h0, vrc_pkg::GAIN_RST});
        wbXfer(0, vrc_pkg::REG_CODE, 0);
        check("code", rd, 0);
        wbXfer(0, vrc_pkg::REG_STATUS, 0);
        check("status", rd, 32'h18);
    endtask

    task automatic testStartup();
        wbXfer(1, vrc_pkg::REG_CMD, 32'h504);
        repeat (10) @(posedge ref_clk);
        check("en float", mainDrive.pulseEn, 0);
        check("drv off", mainDrive.driverEnable, 0);
        mainRaw.overVoltage <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("overvolt low side", lowSideOn, 32'h3f);
        mainRaw.overVoltage <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("en float2", mainDrive.pulseEn, 0);
        pwmReq <= 2'b01;
        // the start only ends once the reference has left the off code
        waitMain(8'h01, 200);
        repeat (4) @(posedge ref_clk);
        check("drv on", mainDrive.driverEnable, 1);
        check("en on", mainDrive.pulseEn, 32'h3f);
        waitMain(8'h04, 2000);
        repeat (UNMASK + 6) @(posedge ref_clk);
    endtask

    task automatic testSlope();
        wbXfer(1, vrc_pkg::REG_CMD, 32'h508);
        waitMain(8'h08, 2000);
        check("fast", n > 4 * vrc_pkg::FAST_STEP_CYC - 12, 1);
        check("fast2", n < 4 * vrc_pkg::FAST_STEP_CYC + 8, 1);
        wbXfer(1, vrc_pkg::REG_CMD, 32'h107);
        repeat (50) @(posedge ref_clk);
        mainRaw.underVoltage <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("under masked", mainFlags.underVoltage, 0);
        waitMain(8'h07, 600);
        n = n + 54;
        check("slow", n > vrc_pkg::SLOW_STEP_CYC - 12, 1);
        check("slow2", n < vrc_pkg::SLOW_STEP_CYC + 8, 1);
        check("under held", mainFlags.underVoltage, 0);
        repeat (UNMASK + 6) @(posedge ref_clk);
        check("under back", mainFlags.underVoltage, 1);
        mainRaw.underVoltage <= 1'b0;
    endtask

    task automatic testRetarget();
        logic [7:0] peak;
        wbXfer(1, vrc_pkg::REG_CMD, 32'h514);
        waitMain(8'h0a, 2000);
        wbXfer(1, vrc_pkg::REG_CMD, 32'h502);
        peak = mainRef;
        n = 0;
        while (mainRef !== 8'h02 && n < 2000)
        begin
            @(posedge ref_clk);
            n++;
            peak = (mainRef > peak) ? mainRef : peak;
        end
        check("retarget end", mainRef, 32'h02);
        check("no old target", peak < 8'h0c, 1);
    endtask

    task automatic testDroop();
        loadLevel <= 10'd10;
        wbXfer(1, vrc_pkg::REG_CMD, 32'h20000);
        repeat (4) @(posedge ref_clk);
        check("droop", droopOut, 60);
        wbXfer(1, vrc_pkg::REG_GAIN, 32'h20);
        repeat (4) @(posedge ref_clk);
        check("droop gain", droopOut, 120);
        wbXfer(1, vrc_pkg::REG_CMD, 32'h30000);
        repeat (4) @(posedge ref_clk);
        check("droop mem", droopOut, 30);
        wbXfer(0, vrc_pkg::REG_CMD, 0);
        check("cmd read", rd, 32'h30000);
    endtask

    task automatic testStrap();
        strap <= 1'b1;
        doReset();
        wbXfer(1, vrc_pkg::REG_CMD, 32'h205);
        repeat (300) @(posedge ref_clk);
        check("single ref", singleRef, 0);
        wbXfer(0, vrc_pkg::REG_STATUS, 0);
        check("refused", rd & 32'h60, 32'h60);
        wbXfer(1, vrc_pkg::REG_STATUS, 0);
        wbXfer(0, vrc_pkg::REG_STATUS, 0);
        check("refused clr", rd & 32'h40, 0);
        strap <= 1'b0;
        doReset();
        // enabled single section now follows a fast command
        wbXfer(1, vrc_pkg::REG_CMD, 32'h601);
        repeat (vrc_pkg::FAST_STEP_CYC + 8) @(posedge ref_clk);
        check("single ramp", singleRef, 32'h01);
    endtask

    task automatic testLatch();
        wbXfer(1, vrc_pkg::REG_CMD, 32'h50a);
        repeat (20) @(posedge ref_clk);
        limitSense <= 1'b1;
        // three-flop filter, then latch, then driver registers
        repeat (8) @(posedge ref_clk);
        check("latched", latchedOff, 1);
        check("latch drv", mainDrive.driverEnable, 0);
        check("latch hiz", mainDrive.pulseEn, 0);
        limitSense <= 1'b0;
        wbXfer(0, vrc_pkg::REG_STATUS, 0);
        check("latch stat", rd[7], 1);
    endtask

    // main sequence
    initial
    begin
        rst_b = 1'b0;
        {wbCyc, wbStb, wbWe, strap, limitSense} = 5'h0;
        wbAdr = 4'h0;
        wbDat = 32'h0;
        pwmReq = 2'b00;
        loadLevel = 10'h0;
        mainRaw = 3'h0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        testResetValues();
        testStartup();
        testSlope();
        testRetarget();
        testDroop();
        testStrap();
        testLatch();
        give_verdict();
    end
endmodule
